/* File: rtl/pmc_delay.sv */
// one-shot countdown: done pulses CYC cycles after start
`timescale 1ns/1ps
module pmc_delay #(
	parameter int CYC = 5,
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic abort,
	output logic done
);
	logic [W-1:0] cnt;
	logic run;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
			run <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				run <= 1'b0;
			end else if (start) begin
				cnt <= W'(CYC - 1);
				run <= 1'b1;
			end else if (run) begin
				if (cnt == '0) begin
					run <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt <= cnt - 1'b1;
				end
			end
		end
	end
endmodule

/* File: rtl/pmc_pkg.sv */
// constants, field layout and state encoding of the power mode control block
package pmc_pkg;
	// ----------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------
	localparam logic [7:0] TRIG_REG_IDX = 8'h87;
	localparam logic [7:0] SLEEP_REG_IDX = 8'hBE;
	localparam int ADR_W = 10;
	localparam int DAT_W = 32;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int TRIG_BIT = 0;
	localparam int HALT_BIT = 1;
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 1;
	localparam int PD_BIT = 2;
	localparam int CAUSE_LSB = 3;
	localparam int CAUSE_MSB = 4;
	localparam int RC_RDY_BIT = 5;
	localparam int XO_RDY_BIT = 6;
	localparam int SBUS_EN_BIT = 7;
	localparam int REG_W = 8;
	// ----------------------------------------
	// reset values and encodings
	// ----------------------------------------
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic PD_RST = 1'b1;
	localparam logic SBUS_EN_RST = 1'b0;
	localparam logic [1:0] PS_ZERO = 2'h0;
	localparam logic [1:0] PS_ONE = 2'h1;
	localparam logic [1:0] PS_TWO = 2'h2;
	localparam logic [1:0] PS_THREE = 2'h3;
	localparam logic [1:0] CAUSE_POR = 2'h0;
	localparam logic [1:0] CAUSE_EXT = 2'h1;
	localparam logic [1:0] CAUSE_WDT = 2'h2;
	localparam logic CLK_SRC_XOSC = 1'b0;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_NS = 10;
	localparam int PD_SEQ_NS = 50;
	localparam int PD_SEQ_CYC = (PD_SEQ_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] CAUSE_CAPTURE_CYC = 2'h2;
	// ----------------------------------------
	// operating states, gray along active-down-sleep-wake
	// ----------------------------------------
	typedef enum logic [2:0] {
		PMC_ACTIVE = 3'h0,
		PMC_DOZE = 3'h1,
		PMC_DOWN = 3'h4,
		PMC_SLEEP = 3'h6,
		PMC_WAKE = 3'h2
	} pmc_state_t;
endpackage

/* File: rtl/pmc_sync.sv */
// two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module pmc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

/* File: rtl/pmc_top.sv */
// power mode control: trigger and sleep registers, state sequencing, oscillator control
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
module pmc_top #(
	parameter int PD_CYC = pmc_pkg::PD_SEQ_CYC
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [pmc_pkg::ADR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [pmc_pkg::DAT_W-1:0] WB_DAT_I,
	output logic [pmc_pkg::DAT_W-1:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic IRQ_REQ,
	input wire logic PIN_IRQ,
	input wire logic SLEEP_TIMER_IRQ,
	input wire logic XOSC_STABLE,
	input wire logic RC_STABLE,
	input wire logic RST_SRC_EXT,
	input wire logic RST_SRC_WDT,
	input wire logic CLK_SRC_SEL,
	input wire logic CAL_BUSY,
	output logic XOSC_PWR_EN,
	output logic RC_PWR_EN,
	output logic SYS_CLK_FROM_RC,
	output logic CPU_CLK_GATE,
	output logic CPU_HALT,
	output logic PERIPH_CLK_EN,
	output logic CORE_REG_EN,
	output logic SLOW_OSC_EN,
	output logic WAKE_IRQ_BLOCK,
	output logic SERIAL_BUS_EN,
	output logic SERIAL_BUS_RST
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [5:0] async_in;
	logic [5:0] async_s;
	logic pin_irq_s;
	logic timer_irq_s;
	logic xosc_stable_s;
	logic rc_stable_s;
	logic rst_ext_s;
	logic rst_wdt_s;

	assign async_in = {RST_SRC_WDT, RST_SRC_EXT, RC_STABLE, XOSC_STABLE,
		SLEEP_TIMER_IRQ, PIN_IRQ};

	pmc_sync #(
		.W(6)
	) u_sync (
		.clk(SYS_CLK),
		.rst(RST),
		.d(async_in),
		.q(async_s)
	);

	assign pin_irq_s = async_s[0];
	assign timer_irq_s = async_s[1];
	assign xosc_stable_s = async_s[2];
	assign rc_stable_s = async_s[3];
	assign rst_ext_s = async_s[4];
	assign rst_wdt_s = async_s[5];

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic ack;
	logic req;
	logic hit_trig;
	logic hit_sleep;
	logic wr_trig;
	logic wr_sleep;
	logic [pmc_pkg::REG_W-1:0] wdat;

	assign req = WB_CYC_I & WB_STB_I & ~ack;
	assign hit_trig = WB_ADR_I[pmc_pkg::ADR_W-1:2] == pmc_pkg::TRIG_REG_IDX;
	assign hit_sleep = WB_ADR_I[pmc_pkg::ADR_W-1:2] == pmc_pkg::SLEEP_REG_IDX;
	// only lane 0 carries register bits; other lanes are ignored
	assign wr_trig = req & WB_WE_I & WB_SEL_I[0] & hit_trig;
	assign wr_sleep = req & WB_WE_I & WB_SEL_I[0] & hit_sleep;
	assign wdat = WB_DAT_I[pmc_pkg::REG_W-1:0];

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	pmc_pkg::pmc_state_t state;
	logic [1:0] mode;
	logic [1:0] depth;
	logic unused_fast_clock_powerdown;
	logic pd_pending;
	logic clk_src_q;
	logic [1:0] cause;
	logic [1:0] rel_cnt;
	logic xosc_ready;
	logic rc_ready;
	logic sbus_en;
	logic next_sbus_en;
	logic enter_deep;
	logic enter_doze;
	logic down_done;
	logic wake_src;
	logic src_toggle;
	logic hs_on;
	logic clock_ok;
	logic [pmc_pkg::REG_W-1:0] sleep_rd;

	assign enter_deep = (state == pmc_pkg::PMC_ACTIVE) & wr_trig
		& wdat[pmc_pkg::TRIG_BIT] & (mode != pmc_pkg::PS_ZERO);
	assign enter_doze = (state == pmc_pkg::PMC_ACTIVE) & wr_trig
		& wdat[pmc_pkg::TRIG_BIT] & (mode == pmc_pkg::PS_ZERO);
	// state three has no slow clock, so the sleep timer cannot wake it
	assign wake_src = pin_irq_s
		| (timer_irq_s & (depth != pmc_pkg::PS_THREE));
	assign src_toggle = CLK_SRC_SEL != clk_src_q;
	assign hs_on = state != pmc_pkg::PMC_SLEEP;
	assign clock_ok = xosc_ready | rc_ready;

	// ----------------------------------------
	// power-down sequence timer
	// ----------------------------------------
	pmc_delay #(
		.CYC(PD_CYC),
		.W(16)
	) u_pd_delay (
		.clk(SYS_CLK),
		.rst(RST),
		.start(enter_deep),
		.abort(wake_src),
		.done(down_done)
	);

	// ----------------------------------------
	// operating state machine
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			state <= pmc_pkg::PMC_ACTIVE;
		end else begin
			case (state)
				pmc_pkg::PMC_ACTIVE: begin
					if (enter_deep) begin
						state <= pmc_pkg::PMC_DOWN;
					end else if (enter_doze) begin
						state <= pmc_pkg::PMC_DOZE;
					end
				end
				pmc_pkg::PMC_DOZE: begin
					if (IRQ_REQ) begin
						state <= pmc_pkg::PMC_ACTIVE;
					end
				end
				pmc_pkg::PMC_DOWN: begin
					// an early wake event aborts the sequence
					if (wake_src) begin
						state <= pmc_pkg::PMC_WAKE;
					end else if (down_done) begin
						state <= pmc_pkg::PMC_SLEEP;
					end
				end
				pmc_pkg::PMC_SLEEP: begin
					if (wake_src) begin
						state <= pmc_pkg::PMC_WAKE;
					end
				end
				pmc_pkg::PMC_WAKE: begin
					if (clock_ok) begin
						state <= pmc_pkg::PMC_ACTIVE;
					end
				end
				default: begin
					state <= pmc_pkg::PMC_ACTIVE;
				end
			endcase
		end
	end

	// depth of the current low power state
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			depth <= pmc_pkg::PS_ZERO;
		end else if (enter_deep) begin
			depth <= mode;
		end
	end

	// ----------------------------------------
	// state field
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			mode <= pmc_pkg::MODE_RST;
		end else if (enter_deep) begin
			mode <= pmc_pkg::PS_ZERO;
		end else if (wr_sleep) begin
			mode <= wdat[pmc_pkg::MODE_MSB:pmc_pkg::MODE_LSB];
		end
	end

	// ----------------------------------------
	// processor halt from reserved bit
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			CPU_HALT <= 1'b0;
		end else if (wr_trig & wdat[pmc_pkg::HALT_BIT]) begin
			CPU_HALT <= 1'b1;
		end
	end

	// ----------------------------------------
	// oscillator powerdown policy
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			clk_src_q <= 1'b0;
		end else begin
			clk_src_q <= CLK_SRC_SEL;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			unused_fast_clock_powerdown <= pmc_pkg::PD_RST;
			pd_pending <= 1'b0;
		end else if (src_toggle) begin
			unused_fast_clock_powerdown <= 1'b0;
			pd_pending <= 1'b0;
		end else if (wr_sleep) begin
			if (!wdat[pmc_pkg::PD_BIT]) begin
				unused_fast_clock_powerdown <= 1'b0;
				pd_pending <= 1'b0;
			end else if (CAL_BUSY) begin
				pd_pending <= 1'b1;
			end else begin
				unused_fast_clock_powerdown <= 1'b1;
			end
		end else if (pd_pending & ~CAL_BUSY) begin
			unused_fast_clock_powerdown <= 1'b1;
			pd_pending <= 1'b0;
		end
	end

	// ----------------------------------------
	// oscillator power and ready flags
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			XOSC_PWR_EN <= 1'b0;
			RC_PWR_EN <= 1'b0;
		end else begin
			XOSC_PWR_EN <= hs_on
				& (~unused_fast_clock_powerdown | (CLK_SRC_SEL == pmc_pkg::CLK_SRC_XOSC));
			// rc stays up while the crystal is still settling
			RC_PWR_EN <= hs_on & (~unused_fast_clock_powerdown
				| (CLK_SRC_SEL != pmc_pkg::CLK_SRC_XOSC) | ~xosc_ready);
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			xosc_ready <= 1'b0;
			rc_ready <= 1'b0;
		end else begin
			xosc_ready <= XOSC_PWR_EN & xosc_stable_s;
			rc_ready <= RC_PWR_EN & rc_stable_s;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			SYS_CLK_FROM_RC <= 1'b1;
		end else begin
			SYS_CLK_FROM_RC <= (CLK_SRC_SEL != pmc_pkg::CLK_SRC_XOSC)
				| ~xosc_ready;
		end
	end

	// ----------------------------------------
	// reset cause, caught after release
	// ----------------------------------------
	// waits out the synchroniser so the latched source is valid
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			rel_cnt <= 2'h0;
			cause <= pmc_pkg::CAUSE_POR;
		end else if (rel_cnt != '1) begin
			rel_cnt <= rel_cnt + 2'h1;
			// synchroniser is cleared by reset too; its second stage is valid from edge three
			if (rel_cnt == pmc_pkg::CAUSE_CAPTURE_CYC) begin
				if (rst_wdt_s) begin
					cause <= pmc_pkg::CAUSE_WDT;
				end else if (rst_ext_s) begin
					cause <= pmc_pkg::CAUSE_EXT;
				end else begin
					cause <= pmc_pkg::CAUSE_POR;
				end
			end
		end
	end

	// ----------------------------------------
	// serial bus controller enable
	// ----------------------------------------
	always_comb begin
		next_sbus_en = sbus_en;
		if ((state == pmc_pkg::PMC_SLEEP) & wake_src & depth[1]) begin
			next_sbus_en = 1'b0;
		end else if (wr_sleep) begin
			next_sbus_en = wdat[pmc_pkg::SBUS_EN_BIT];
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			sbus_en <= pmc_pkg::SBUS_EN_RST;
			SERIAL_BUS_EN <= pmc_pkg::SBUS_EN_RST;
			SERIAL_BUS_RST <= 1'b1;
		end else begin
			sbus_en <= next_sbus_en;
			SERIAL_BUS_EN <= next_sbus_en;
			SERIAL_BUS_RST <= ~next_sbus_en;
		end
	end

	// ----------------------------------------
	// clock, regulator and interrupt gating
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			CPU_CLK_GATE <= 1'b0;
			PERIPH_CLK_EN <= 1'b1;
			CORE_REG_EN <= 1'b1;
			SLOW_OSC_EN <= 1'b1;
			WAKE_IRQ_BLOCK <= 1'b0;
		end else begin
			CPU_CLK_GATE <= state != pmc_pkg::PMC_ACTIVE;
			PERIPH_CLK_EN <= (state == pmc_pkg::PMC_ACTIVE)
				| (state == pmc_pkg::PMC_DOZE);
			CORE_REG_EN <= ~((state == pmc_pkg::PMC_SLEEP) & depth[1]);
			SLOW_OSC_EN <= ~((state == pmc_pkg::PMC_SLEEP)
				& (depth == pmc_pkg::PS_THREE));
			// keeps a stray wake source from firing between arming and trigger
			WAKE_IRQ_BLOCK <= mode != pmc_pkg::PS_ZERO;
		end
	end

	// ----------------------------------------
	// bus answer
	// ----------------------------------------
	always_comb begin
		sleep_rd = '0;
		sleep_rd[pmc_pkg::SBUS_EN_BIT] = sbus_en;
		sleep_rd[pmc_pkg::XO_RDY_BIT] = xosc_ready;
		sleep_rd[pmc_pkg::RC_RDY_BIT] = rc_ready;
		sleep_rd[pmc_pkg::CAUSE_MSB:pmc_pkg::CAUSE_LSB] = cause;
		sleep_rd[pmc_pkg::PD_BIT] = unused_fast_clock_powerdown;
		sleep_rd[pmc_pkg::MODE_MSB:pmc_pkg::MODE_LSB] = mode;
	end

	// single wait state; unmapped addresses answer with zero
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ack <= 1'b0;
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= '0;
		end else begin
			ack <= req;
			WB_ACK_O <= req;
			if (req & ~WB_WE_I & hit_sleep) begin
				WB_DAT_O <= {{(pmc_pkg::DAT_W - pmc_pkg::REG_W){1'b0}}, sleep_rd};
			end else begin
				WB_DAT_O <= '0;
			end
		end
	end
endmodule

/* File: tb/pmc_top_assertions.sv */
// port-level checker for the power mode control block
`timescale 1ns/1ps
module pmc_top_assertions (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [pmc_pkg::ADR_W-1:0] WB_ADR_I,
	input wire logic [pmc_pkg::DAT_W-1:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic IRQ_REQ,
	input wire logic CPU_CLK_GATE,
	input wire logic CPU_HALT,
	input wire logic XOSC_PWR_EN,
	input wire logic SERIAL_BUS_EN,
	input wire logic SERIAL_BUS_RST
);
	// ----------------------------------------
	// sequences
	// ----------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	sequence s_req;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	sequence s_rd(idx);
		WB_ACK_O && !WB_WE_I && WB_ADR_I[9:2] == idx;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_ack;
		s_req |=> WB_ACK_O;
	endproperty
	a_ack: assert property (p_ack) else $error("request not answered in one cycle");
	property p_pulse;
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
	property p_trig_rd;
		s_rd(pmc_pkg::TRIG_REG_IDX) |-> WB_DAT_O == 32'h0;
	endproperty
	a_trig_rd: assert property (p_trig_rd) else $error("trigger read not zero");
	property p_unmap;
		WB_ACK_O && !WB_WE_I && WB_ADR_I[9:2] != pmc_pkg::TRIG_REG_IDX
			&& WB_ADR_I[9:2] != pmc_pkg::SLEEP_REG_IDX |-> WB_DAT_O == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_sbus_rd;
		s_rd(pmc_pkg::SLEEP_REG_IDX) |-> WB_DAT_O[7] == SERIAL_BUS_EN;
	endproperty
	a_sbus_rd: assert property (p_sbus_rd) else $error("serial enable readback differs");
	property p_sbus_rst;
		SERIAL_BUS_RST == !SERIAL_BUS_EN;
	endproperty
	a_sbus_rst: assert property (p_sbus_rst) else $error("serial reset not inverse");
	// one cycle of slack: flag and power are registered separately
	property p_xo_rdy;
		s_rd(pmc_pkg::SLEEP_REG_IDX) ##0 WB_DAT_O[6] |-> XOSC_PWR_EN || $past(XOSC_PWR_EN);
	endproperty
	a_xo_rdy: assert property (p_xo_rdy) else $error("crystal ready while unpowered");
	property p_wake;
		CPU_CLK_GATE && IRQ_REQ |-> ##[1:3] !CPU_CLK_GATE;
	endproperty
	a_wake: assert property (p_wake) else $error("interrupt did not end idle");
	property p_halt;
		CPU_HALT |=> CPU_HALT;
	endproperty
	a_halt: assert property (p_halt) else $error("halt released without reset");
endmodule

/* File: tb/pmc_top_tb_top.sv */
// self-checking bench for the power mode control block
`timescale 1ns/1ps
module pmc_top_tb_top;
	localparam int PD = 5;
	localparam logic [7:0] TRG = pmc_pkg::TRIG_REG_IDX;
	localparam logic [7:0] SLP = pmc_pkg::SLEEP_REG_IDX;
	logic SYS_CLK = 1'b0;
	logic RST = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, irq = 1'b0, pin = 1'b0, tmr = 1'b0;
	logic xo_st = 1'b0, rc_st = 1'b0, ext = 1'b0, wdt = 1'b0, src = 1'b0, cal = 1'b0;
	logic xo_ok = 1'b0, rc_ok = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h00000000;
	logic [31:0] dat_o;
	logic ack, xo_pw, rc_pw, from_rc, gate, halt, per_en, core_en, slow_en, blk, sb_en, sb_rst;
	int miscompares = 0;
	int total_checks = 0;
	always #5 SYS_CLK = ~SYS_CLK;
	// stable levels trail oscillator power by a cycle, so one never looks ready before it is powered
	always @(posedge SYS_CLK) begin
		xo_st <= xo_pw & xo_ok;
		rc_st <= rc_pw & rc_ok;
	end
	pmc_top #(.PD_CYC(PD)) u_dut (.SYS_CLK(SYS_CLK), .RST(RST), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .IRQ_REQ(irq), .PIN_IRQ(pin), .SLEEP_TIMER_IRQ(tmr), .XOSC_STABLE(xo_st),
		.RC_STABLE(rc_st), .RST_SRC_EXT(ext), .RST_SRC_WDT(wdt), .CLK_SRC_SEL(src),
		.CAL_BUSY(cal), .XOSC_PWR_EN(xo_pw), .RC_PWR_EN(rc_pw), .SYS_CLK_FROM_RC(from_rc),
		.CPU_CLK_GATE(gate), .CPU_HALT(halt), .PERIPH_CLK_EN(per_en), .CORE_REG_EN(core_en),
		.SLOW_OSC_EN(slow_en), .WAKE_IRQ_BLOCK(blk), .SERIAL_BUS_EN(sb_en),
		.SERIAL_BUS_RST(sb_rst));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(posedge SYS_CLK);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hF;
		adr <= {idx, 2'h0};
		dat <= {24'h000000, d};
		do begin
			@(posedge SYS_CLK);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dat_o[7:0];
		if (n >= 20) begin
			miscompares++;
			end_of_test();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, idx, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] exp);
		logic [7:0] q;
		wb(1'b0, idx, 8'h00, q);
		chk(q & m, exp);
	endtask
	task automatic do_reset();
		RST <= 1'b1;
		repeat (8) @(posedge SYS_CLK);
		RST <= 1'b0;
		repeat (3) @(posedge SYS_CLK);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd_chk(SLP, 8'hFF, 8'h04);
		rd_chk(TRG, 8'hFF, 8'h00);
		rd_chk(8'h00, 8'hFF, 8'h00);
		chk(8'(sb_rst), 8'h01);
		$display("test reset values done");
	endtask
	task automatic t_osc();
		xo_ok <= 1'b1;
		rc_ok <= 1'b1;
		repeat (12) @(posedge SYS_CLK);
		chk(8'(rc_pw), 8'h00);
		rd_chk(SLP, 8'hFF, 8'h44);
		wr(SLP, 8'h00);
		repeat (8) @(posedge SYS_CLK);
		rd_chk(SLP, 8'hFF, 8'h60);
		$display("test oscillator flags done");
	endtask
	task automatic t_policy();
		cal <= 1'b1;
		wr(SLP, 8'h04);
		rd_chk(SLP, 8'h04, 8'h00);
		cal <= 1'b0;
		repeat (3) @(posedge SYS_CLK);
		rd_chk(SLP, 8'h04, 8'h04);
		src <= 1'b1;
		repeat (2) @(posedge SYS_CLK);
		rd_chk(SLP, 8'h04, 8'h00);
		src <= 1'b0;
		repeat (8) @(posedge SYS_CLK);
		$display("test powerdown policy done");
	endtask
	task automatic t_doze();
		wr(SLP, 8'h80);
		repeat (2) @(posedge SYS_CLK);
		chk({7'h00, sb_rst}, 8'h00);
		wr(TRG, 8'h01);
		repeat (4) @(posedge SYS_CLK);
		chk(8'(gate), 8'h01);
		chk(8'(per_en), 8'h01);
		irq <= 1'b1;
		repeat (4) @(posedge SYS_CLK);
		chk(8'(gate), 8'h00);
		irq <= 1'b0;
		$display("test idle state done");
	endtask
	task automatic t_deep(input logic [1:0] m);
		int n;
		wr(SLP, {6'h20, m});
		repeat (2) @(posedge SYS_CLK);
		chk(8'(blk), 8'h01);
		wr(TRG, 8'h01);
		rd_chk(SLP, 8'h03, 8'h00);
		repeat (PD + 6) @(posedge SYS_CLK);
		chk({6'h00, per_en, xo_pw | rc_pw}, 8'h00);
		chk({6'h00, core_en, slow_en}, {6'h00, m == pmc_pkg::PS_ONE, m != pmc_pkg::PS_THREE});
		if (m == pmc_pkg::PS_THREE) begin
			tmr <= 1'b1;
			repeat (8) @(posedge SYS_CLK);
			chk(8'(per_en), 8'h00);
			tmr <= 1'b0;
			pin <= 1'b1;
		end else begin
			tmr <= 1'b1;
		end
		for (n = 0; n < 100 && xo_pw !== 1'b1; n++) @(posedge SYS_CLK);
		chk(8'(from_rc), 8'h01);
		for (n = 0; n < 100 && per_en !== 1'b1; n++) @(posedge SYS_CLK);
		chk(8'(sb_en), 8'(m == pmc_pkg::PS_ONE));
		chk(8'(blk), 8'h00);
		wr(SLP, 8'h00);
		pin <= 1'b0;
		tmr <= 1'b0;
		repeat (8) @(posedge SYS_CLK);
		chk(8'(from_rc), 8'h00);
		$display("test deep state %0d done", m);
	endtask
	task automatic t_cause();
		logic [7:0] exp [3];
		exp = '{8'h08, 8'h10, 8'h00};
		wr(TRG, 8'h02);
		repeat (2) @(posedge SYS_CLK);
		chk(8'(halt), 8'h01);
		for (int i = 0; i < 3; i++) begin
			ext <= (i == 0);
			wdt <= (i == 1);
			do_reset();
			rd_chk(SLP, 8'h18, exp[i]);
			chk(8'(halt), 8'h00);
		end
		ext <= 1'b0;
		$display("test reset cause done");
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		do_reset();
		t_reset();
		t_osc();
		t_policy();
		t_doze();
		t_deep(pmc_pkg::PS_ONE);
		t_deep(pmc_pkg::PS_TWO);
		t_deep(pmc_pkg::PS_THREE);
		t_cause();
		end_of_test();
	end
	initial begin
		#100000;
		miscompares++;
		end_of_test();
	end
endmodule
bind pmc_top pmc_top_assertions u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK_O(WB_ACK_O), .IRQ_REQ(IRQ_REQ), .CPU_CLK_GATE(CPU_CLK_GATE), .CPU_HALT(CPU_HALT),
	.XOSC_PWR_EN(XOSC_PWR_EN), .SERIAL_BUS_EN(SERIAL_BUS_EN), .SERIAL_BUS_RST(SERIAL_BUS_RST));
